// >>> pkg/fssr_pkg.sv
package fssr_pkg;
    // serial command codes
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

    // status byte one field positions
    localparam int BIT_LOCK = 7;
    localparam int BIT_FAIL = 5;
    localparam int BIT_PIN = 4;
    localparam int BIT_ARRAY = 2;
    localparam int BIT_WEL = 1;
    localparam int BIT_BUSY = 0;
    // status byte two field positions
    localparam int BIT_SRST = 4;

    // reset values
    localparam logic LOCK_RESET = 1'h0;
    localparam logic ARRAY_RESET = 1'h0;
    localparam logic FAIL_RESET = 1'h0;
    localparam logic WEL_RESET = 1'h0;
    localparam logic SRST_RESET = 1'h0;

    // framing
    localparam int STATUS_BITS = 16;
    localparam logic [3:0] PASS_FIRST = 4'hf;
    localparam logic [2:0] BIT_IDX_ZERO = 3'h0;
    localparam logic [2:0] BIT_IDX_LAST = 3'h7;
    localparam logic [1:0] BYTES_NONE = 2'h0;
    localparam logic [1:0] BYTES_OPCODE = 2'h1;
    localparam logic [1:0] BYTES_DATA = 2'h2;

    // pin synchroniser: {wp_n, si, sck, cs_n}
    localparam int SYNC_STAGES = 2;
    localparam int PIN_COUNT = 4;
    localparam logic [3:0] SYNC_RESET = 4'h9;

    typedef enum logic [2:0] {
        st_idle,
        st_opcode,
        st_stream,
        st_payload,
        st_skip
    } fssr_state_t;
endpackage

// >>> pkg/fssr_link_if.sv
`timescale 1ns/1ns
interface fssr_link_if;
    logic cs_active;
    logic cs_end;
    logic sck_rise;
    logic sck_fall;
    logic opcode_done;
    logic [2:0] bit_idx;
    logic [1:0] byte_cnt;
    logic [7:0] opcode;
    logic [7:0] data_byte;

    modport shifter (
        output cs_active, cs_end, sck_rise, sck_fall, opcode_done,
        output bit_idx, byte_cnt, opcode, data_byte
    );
    modport core (
        input cs_active, cs_end, sck_rise, sck_fall, opcode_done,
        input bit_idx, byte_cnt, opcode, data_byte
    );
endinterface

// >>> hdl/fssr_sync.sv
`timescale 1ns/1ns
module fssr_sync #(
    parameter int WIDTH = 4,
    parameter int STAGES = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // system
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    if (STAGES < 2) begin : g_bad
        $error("fssr_sync needs at least two stages");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic [STAGES-1:0] chain;
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                chain <= {STAGES{RESET_VAL[i]}};
            end else begin
                chain <= {chain[STAGES-2:0], d_i[i]};
            end
        end
        assign q_o[i] = chain[STAGES-1];
    end
endmodule

// >>> hdl/fssr_shifter.sv
`timescale 1ns/1ns
module fssr_shifter (
    // system
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // synchronised pins
    input wire logic cs_n_s_i,
    input wire logic sck_s_i,
    input wire logic si_s_i,
    // framed link towards the core
    fssr_link_if.shifter link
);
    logic sck_d;
    logic cs_active;
    logic cs_end;
    logic opcode_done;
    logic [2:0] bit_idx;
    logic [1:0] byte_cnt;
    logic [7:0] rx;
    logic [7:0] opcode;
    logic [7:0] data_byte;

    wire cs_now = ~cs_n_s_i;
    wire rise = cs_now & sck_s_i & ~sck_d;
    wire fall = cs_now & ~sck_s_i & sck_d;
    wire [7:0] rx_next = {rx[6:0], si_s_i};
    wire byte_done = rise & (bit_idx == fssr_pkg::BIT_IDX_LAST);

    // counters clear one cycle after cs_end so the core sees final counts
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sck_d <= 1'h0;
            cs_active <= 1'h0;
            cs_end <= 1'h0;
            opcode_done <= 1'h0;
            bit_idx <= fssr_pkg::BIT_IDX_ZERO;
            byte_cnt <= fssr_pkg::BYTES_NONE;
            rx <= 8'h00;
            opcode <= 8'h00;
            data_byte <= 8'h00;
        end else begin
            sck_d <= sck_s_i;
            cs_active <= cs_now;
            cs_end <= cs_active & ~cs_now;
            opcode_done <= byte_done & (byte_cnt == fssr_pkg::BYTES_NONE);
            if (!cs_active && !cs_now) begin
                bit_idx <= fssr_pkg::BIT_IDX_ZERO;
                byte_cnt <= fssr_pkg::BYTES_NONE;
            end else if (rise) begin
                rx <= rx_next;
                bit_idx <= bit_idx + 3'h1;
                if (byte_done && byte_cnt == fssr_pkg::BYTES_NONE) begin
                    opcode <= rx_next;
                end
                if (byte_done && byte_cnt == fssr_pkg::BYTES_OPCODE) begin
                    data_byte <= rx_next;
                end
                if (byte_done && byte_cnt != fssr_pkg::BYTES_DATA) begin
                    byte_cnt <= byte_cnt + 2'h1;
                end
            end
        end
    end

    assign link.cs_active = cs_active;
    assign link.cs_end = cs_end;
    assign link.sck_rise = rise;
    assign link.sck_fall = fall;
    assign link.opcode_done = opcode_done;
    assign link.bit_idx = bit_idx;
    assign link.byte_cnt = byte_cnt;
    assign link.opcode = opcode;
    assign link.data_byte = data_byte;
endmodule

// >>> hdl/fssr_top.sv
// Function
// - after read opcode, one status bit per serial clock, top bit first.
// - after byte two bit 0, restart at byte one bit 7 while selected.
// - status read is served at any time, busy or not.
// - every pass of the two bytes shows the current internal state.
// - deselect at any point ends the read and floats the output.
// - only lock bit 7 and array bit 2 of byte one are writable.
// - lock set with protect pin asserted freezes the array protection bit.
// - lock resets to 0; while 0 the array bit is writable.
// - with pin asserted, lock only goes 0 to 1; pin deasserted frees it.
// - fail flag bit 5 updated after each erase/program, 1 means failure.
// - an aborted erase or program never sets the fail flag.
// - bit 4 mirrors the protect pin, 0 while asserted.
// - array bit 2 set protects the whole array against program and erase.
// - with write enable latch 0, write-type commands are rejected.
// - write enable latch is 0 after power-up and device reset.
// - latch cleared on write disable, write-type completion or abort, hold abort.
// - incomplete or unknown opcode leaves the latch unchanged.
// - busy flag bit 0 is 1 during an internal operation.
// - busy flag appears at bit 0 of both status bytes.
// - byte two bit 4 is the reset-command allow bit, default 0, writable.
// - write-status opcode plus one data byte carries lock and array values.
`timescale 1ns/1ns
module fssr_top (
    // system
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // serial link pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    // write-protect pin
    input wire logic wp_n_i,
    // internal operation events, same clock
    input wire logic op_busy_i,
    input wire logic op_done_i,
    input wire logic op_fail_i,
    input wire logic op_abort_i,
    input wire logic hold_abort_i,
    input wire logic dev_reset_i,
    // protection state towards the array
    output logic array_protect_o,
    output logic write_enable_o,
    output logic soft_reset_allow_o
);
    fssr_link_if link ();

    logic [fssr_pkg::PIN_COUNT-1:0] pins_s;
    fssr_pkg::fssr_state_t state;
    fssr_pkg::fssr_state_t next_state;

    // status state
    logic protect_lock_bit;
    logic array_protect_bit;
    logic erase_program_fail_flag;
    logic write_enable_latch;
    logic soft_reset_allow;
    logic ready_busy_flag;
    logic next_protect_lock_bit;
    logic next_array_protect_bit;
    logic next_erase_program_fail_flag;
    logic next_write_enable_latch;
    logic next_soft_reset_allow;

    // output serializer
    logic [fssr_pkg::STATUS_BITS-1:0] pass_shadow;
    logic [3:0] out_idx;
    logic so;
    logic so_oe;
    logic [7:0] status_one;
    logic [7:0] status_two;

    fssr_sync #(
        .WIDTH(fssr_pkg::PIN_COUNT),
        .STAGES(fssr_pkg::SYNC_STAGES),
        .RESET_VAL(fssr_pkg::SYNC_RESET)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .d_i({wp_n_i, si_i, sck_i, cs_n_i}),
        .q_o(pins_s)
    );

    fssr_shifter u_shifter (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .cs_n_s_i(pins_s[0]),
        .sck_s_i(pins_s[1]),
        .si_s_i(pins_s[2]),
        .link(link)
    );

    wire protect_pin_state = pins_s[3];
    wire pin_asserted = ~protect_pin_state;

    // live status bytes
    always_comb begin
        status_one = 8'h00;
        status_two = 8'h00;
        status_one[fssr_pkg::BIT_LOCK] = protect_lock_bit;
        status_one[fssr_pkg::BIT_ARRAY] = array_protect_bit;
        status_one[fssr_pkg::BIT_FAIL] = erase_program_fail_flag;
        status_one[fssr_pkg::BIT_PIN] = protect_pin_state;
        status_one[fssr_pkg::BIT_WEL] = write_enable_latch;
        status_one[fssr_pkg::BIT_BUSY] = ready_busy_flag;
        status_two[fssr_pkg::BIT_BUSY] = ready_busy_flag;
        status_two[fssr_pkg::BIT_SRST] = soft_reset_allow;
        // bits 6 and 3 left at zero
    end

    wire [fssr_pkg::STATUS_BITS-1:0] live_word = {status_one, status_two};

    // command framing at deselect
    wire full_opcode = link.byte_cnt != fssr_pkg::BYTES_NONE;
    wire on_boundary = link.bit_idx == fssr_pkg::BIT_IDX_ZERO;
    wire only_opcode = (link.byte_cnt == fssr_pkg::BYTES_OPCODE) & on_boundary;
    wire data_whole = (link.byte_cnt == fssr_pkg::BYTES_DATA) & on_boundary;
    wire idle_dev = ~ready_busy_flag;
    wire frame_end = link.cs_end & full_opcode & idle_dev;

    wire is_wrsr = link.opcode == fssr_pkg::OP_WRITE_STATUS;
    wire is_wrsr2 = link.opcode == fssr_pkg::OP_WRITE_STATUS2;
    wire is_wren = link.opcode == fssr_pkg::OP_WRITE_ENABLE;
    wire is_wrdi = link.opcode == fssr_pkg::OP_WRITE_DISABLE;
    wire is_status_write = is_wrsr | is_wrsr2;

    wire write_allowed = write_enable_latch;
    wire wsr_commit = frame_end & is_wrsr & data_whole & write_allowed;
    wire wsr2_commit = frame_end & is_wrsr2 & data_whole & write_allowed;

    wire req_lock = link.data_byte[fssr_pkg::BIT_LOCK];
    wire req_array = link.data_byte[fssr_pkg::BIT_ARRAY];
    wire req_srst = link.data_byte[fssr_pkg::BIT_SRST];

    // clearing lock under asserted pin drops the whole write
    wire lock_clear_blocked = pin_asserted & protect_lock_bit & ~req_lock;
    wire wsr_apply = wsr_commit & ~lock_clear_blocked;
    // prior lock with pin asserted freezes the array bit
    wire array_frozen = protect_lock_bit & pin_asserted;

    wire wel_clear_cmd = frame_end & (is_status_write | (is_wrdi & only_opcode));
    wire wel_clear_op = op_done_i | op_abort_i | hold_abort_i;
    wire wel_set = frame_end & is_wren & only_opcode;

    // protection and latch next values
    always_comb begin
        next_protect_lock_bit = protect_lock_bit;
        next_array_protect_bit = array_protect_bit;
        next_soft_reset_allow = soft_reset_allow;
        next_erase_program_fail_flag = erase_program_fail_flag;
        next_write_enable_latch = write_enable_latch;
        if (wsr_apply) begin
            next_protect_lock_bit = req_lock;
        end
        if (wsr_apply && !array_frozen) begin
            next_array_protect_bit = req_array;
        end
        if (wsr2_commit) begin
            next_soft_reset_allow = req_srst;
        end
        // fail flag follows each completed operation
        if (op_done_i) begin
            next_erase_program_fail_flag = op_fail_i;
        end
        // command clears need a full write-type opcode; done, abort and hold abort clear without one
        if (wel_clear_cmd || wel_clear_op) begin
            next_write_enable_latch = 1'h0;
        end
        // set beats a same-cycle completion clear
        if (wel_set) begin
            next_write_enable_latch = 1'h1;
        end
        // device reset always leaves the latch at 0
        if (dev_reset_i) begin
            next_write_enable_latch = 1'h0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            protect_lock_bit <= fssr_pkg::LOCK_RESET;
            array_protect_bit <= fssr_pkg::ARRAY_RESET;
            erase_program_fail_flag <= fssr_pkg::FAIL_RESET;
            write_enable_latch <= fssr_pkg::WEL_RESET;
            soft_reset_allow <= fssr_pkg::SRST_RESET;
            ready_busy_flag <= 1'h0;
        end else begin
            protect_lock_bit <= next_protect_lock_bit;
            array_protect_bit <= next_array_protect_bit;
            erase_program_fail_flag <= next_erase_program_fail_flag;
            write_enable_latch <= next_write_enable_latch;
            soft_reset_allow <= next_soft_reset_allow;
            // busy while an internal operation runs
            ready_busy_flag <= op_busy_i;
        end
    end

    // command sequencing
    always_comb begin
        next_state = state;
        case (state)
            fssr_pkg::st_idle: begin
                if (link.cs_active) begin
                    next_state = fssr_pkg::st_opcode;
                end
            end
            fssr_pkg::st_opcode: begin
                if (link.opcode_done) begin
                    if (link.opcode == fssr_pkg::OP_READ_STATUS) begin
                        next_state = fssr_pkg::st_stream;
                    end else if (is_status_write) begin
                        next_state = fssr_pkg::st_payload;
                    end else begin
                        next_state = fssr_pkg::st_skip;
                    end
                end
            end
            fssr_pkg::st_stream: next_state = state;
            fssr_pkg::st_payload: next_state = state;
            fssr_pkg::st_skip: next_state = state;
            default: next_state = fssr_pkg::st_idle;
        endcase
        if (!link.cs_active) begin
            next_state = fssr_pkg::st_idle;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= fssr_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    // status streaming
    wire streaming = state == fssr_pkg::st_stream;
    wire shift_out = streaming & link.sck_fall & link.cs_active;
    wire pass_start = out_idx == fssr_pkg::PASS_FIRST;
    // first bit of each pass comes from live state
    wire out_bit = pass_start ? live_word[fssr_pkg::STATUS_BITS-1] : pass_shadow[out_idx];

    // snapshot per pass keeps each pass self-consistent
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pass_shadow <= '0;
            out_idx <= fssr_pkg::PASS_FIRST;
            so <= 1'h0;
            so_oe <= 1'h0;
        end else if (!link.cs_active || !streaming) begin
            out_idx <= fssr_pkg::PASS_FIRST;
            so <= 1'h0;
            so_oe <= 1'h0;
        end else if (shift_out) begin
            // fresh snapshot at each pass start
            if (pass_start) begin
                pass_shadow <= live_word;
            end
            so <= out_bit;
            so_oe <= 1'h1;
            // wrap from 0 back to 15
            out_idx <= out_idx - 4'h1;
        end
    end

    assign so_o = so;
    assign so_oe_o = so_oe;
    assign array_protect_o = array_protect_bit;
    assign write_enable_o = write_enable_latch;
    assign soft_reset_allow_o = soft_reset_allow;
endmodule

// >>> tb/fssr_monitor.sv
`timescale 1ns/1ns
module fssr_monitor (
    // system
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // serial link
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    // events
    input wire logic op_done_i,
    input wire logic op_abort_i,
    input wire logic hold_abort_i,
    input wire logic dev_reset_i,
    // state
    input wire logic array_protect_o,
    input wire logic write_enable_o,
    input wire logic soft_reset_allow_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // deselected long enough for any frame-end write to have landed
    sequence s_idle;
        cs_n_i [*8];
    endsequence
    sequence s_clear_ev;
        op_done_i || op_abort_i || hold_abort_i;
    endsequence

    a_float_deselect: assert property ($rose(cs_n_i) |-> ##[1:5] !so_oe_o)
        else $error("output still driven after deselect");
    a_so_zero_idle: assert property (!so_oe_o |-> !so_o)
        else $error("undriven output not low");
    a_oe_after_select: assert property ($rose(so_oe_o) |-> $past(cs_n_i, 3) == 1'h0)
        else $error("output enabled without select");
    a_oe_holds: assert property ((so_oe_o && !cs_n_i) |=> so_oe_o)
        else $error("output dropped while selected");
    a_so_on_fall: assert property (($changed(so_o) && so_oe_o) |-> !sck_i)
        else $error("output bit changed while clock high");
    a_reset_clears_wel: assert property (dev_reset_i |=> !write_enable_o)
        else $error("latch kept over device reset");
    a_event_clears_wel: assert property ((s_idle ##0 s_clear_ev) |=> !write_enable_o)
        else $error("latch kept over completion or abort");
    a_wel_stable: assert property ((s_idle ##0
        !(op_done_i || op_abort_i || hold_abort_i || dev_reset_i)) |=> $stable(write_enable_o))
        else $error("latch changed without cause");
    a_array_stable: assert property (s_idle |=> $stable(array_protect_o))
        else $error("array bit changed without a write");
    a_allow_stable: assert property (s_idle |=> $stable(soft_reset_allow_o))
        else $error("reset allow bit changed without a write");
endmodule

bind fssr_top fssr_monitor fssr_monitor_inst (.clk_sys_i, .reset_n_i, .cs_n_i, .sck_i, .so_o,
    .so_oe_o, .op_done_i, .op_abort_i, .hold_abort_i, .dev_reset_i, .array_protect_o,
    .write_enable_o, .soft_reset_allow_o);

// >>> tb/fssr_host_model.sv
`timescale 1ns/1ns
module fssr_host_model (
    // serial link
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    initial begin
        cs_n_o = 1'h1;
        sck_o = 1'h0;
        si_o = 1'h0;
    end

    // mode 0: clock idles low outside frames, input taken on rising edge
    task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0000_0000;
        cs_n_o = 1'h0;
        #60;
        // opcode then data byte, top bit first
        for (int i = 0; i < nbits; i++) begin
            si_o = tx[31];
            tx = tx << 1;
            #62 sck_o = 1'h1;
            rx = {rx[30:0], so_i};
            #63 sck_o = 1'h0;
        end
        #60 cs_n_o = 1'h1;
        // a released data line must not keep its last level
        si_o = ~si_o;
        #300;
    endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk_sys_i;
    logic reset_n_i;
    logic cs_n_i;
    logic sck_i;
    logic si_i;
    logic so_o;
    logic so_oe_o;
    logic wp_n_i;
    logic op_busy_i;
    logic op_done_i;
    logic op_fail_i;
    logic op_abort_i;
    logic hold_abort_i;
    logic dev_reset_i;
    logic array_protect_o;
    logic write_enable_o;
    logic soft_reset_allow_o;
    wire so_line;
    int error_cnt;
    int comparisons;
    logic [31:0] rx;

    // released line reads 1, the inverse of so_o held low while undriven, so a stale sample is caught
    assign so_line = so_oe_o ? so_o : ~so_o;

    fssr_top fssr_top_inst (.clk_sys_i, .reset_n_i, .cs_n_i, .sck_i, .si_i, .so_o, .so_oe_o,
        .wp_n_i, .op_busy_i, .op_done_i, .op_fail_i, .op_abort_i, .hold_abort_i, .dev_reset_i,
        .array_protect_o, .write_enable_o, .soft_reset_allow_o);
    fssr_host_model host_inst (.so_i(so_line), .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i));

    initial begin
        clk_sys_i = 1'h0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic rd_check(input string what, input logic [15:0] exp);
        host_inst.frame({8'h05, 24'h0}, 24, rx);
        check(what, {16'h0, rx[15:0]}, {16'h0, exp});
    endtask
    task automatic cmd(input logic [7:0] op);
        host_inst.frame({op, 24'h0}, 8, rx);
    endtask
    task automatic wrs(input logic [7:0] op, input logic [7:0] d);
        host_inst.frame({op, d, 16'h0}, 16, rx);
    endtask
    // one-cycle pulse of {done, fail, abort, hold, device reset}
    task automatic ev(input logic [4:0] v);
        @(posedge clk_sys_i) #1 {op_done_i, op_fail_i, op_abort_i, hold_abort_i, dev_reset_i} = v;
        @(posedge clk_sys_i) #1 {op_done_i, op_fail_i, op_abort_i, hold_abort_i, dev_reset_i} = 5'h00;
        repeat (3) @(posedge clk_sys_i);
    endtask

    task automatic t_stream();
        rd_check("after reset", 16'h1000);
        host_inst.frame({8'h05, 24'h0}, 40, rx);
        check("two passes", rx, 32'h1000_1000);
        host_inst.frame({8'h05, 24'h0}, 13, rx);
        check("oe mid byte", 32'(so_oe_o), 32'h0000_0000);
    endtask

    task automatic t_wel();
        cmd(8'h06);
        rd_check("latch set", 16'h1200);
        host_inst.frame({8'h04, 24'h0}, 5, rx);
        check("partial op", 32'(write_enable_o), 32'h0000_0001);
        cmd(8'ha5);
        check("unknown op", 32'(write_enable_o), 32'h0000_0001);
        cmd(8'h04);
        check("disable", 32'(write_enable_o), 32'h0000_0000);
        wrs(8'h01, 8'hff);
        check("no latch", 32'(array_protect_o), 32'h0000_0000);
        cmd(8'h06);
        wrs(8'h01, 8'hff);
        check("array out", 32'(array_protect_o), 32'h0000_0001);
        rd_check("write ff", 16'h9400);
    endtask

    task automatic t_lock();
        @(posedge clk_sys_i) #1 wp_n_i = 1'h0;
        cmd(8'h06);
        wrs(8'h01, 8'h00);
        rd_check("lock clear refused", 16'h8400);
        cmd(8'h06);
        wrs(8'h01, 8'h80);
        check("array frozen", 32'(array_protect_o), 32'h0000_0001);
        @(posedge clk_sys_i) #1 wp_n_i = 1'h1;
        cmd(8'h06);
        host_inst.frame({8'h01, 24'h0}, 12, rx);
        rd_check("partial data", 16'h9400);
        cmd(8'h06);
        wrs(8'h01, 8'h00);
        rd_check("lock freed", 16'h1000);
    endtask

    task automatic t_events();
        cmd(8'h06);
        ev(5'h18);
        check("done latch", 32'(write_enable_o), 32'h0000_0000);
        rd_check("fail set", 16'h3000);
        for (int i = 0; i < 3; i++) begin
            cmd(8'h06);
            ev(5'h04 >> i);
            check("event latch", 32'(write_enable_o), 32'h0000_0000);
        end
        rd_check("fail kept", 16'h3000);
        ev(5'h10);
        rd_check("fail clear", 16'h1000);
    endtask

    task automatic t_allow();
        cmd(8'h06);
        wrs(8'h31, 8'h10);
        rd_check("allow set", 16'h1010);
        cmd(8'h06);
        wrs(8'h31, 8'h00);
        check("allow clear", 32'(soft_reset_allow_o), 32'h0000_0000);
    endtask

    task automatic t_busy();
        cmd(8'h06);
        @(posedge clk_sys_i) #1 op_busy_i = 1'h1;
        // write-type commands are ignored while busy
        cmd(8'h04);
        check("busy write", 32'(write_enable_o), 32'h0000_0001);
        rd_check("busy", 16'h1301);
        fork
            host_inst.frame({8'h05, 24'h0}, 40, rx);
            begin
                #2000;
                @(posedge clk_sys_i) #1 op_busy_i = 1'h0;
            end
        join
        check("busy falls", rx, 32'h1301_1200);
    endtask

    initial begin
        reset_n_i = 1'h0;
        wp_n_i = 1'h1;
        op_busy_i = 1'h0;
        {op_done_i, op_fail_i, op_abort_i, hold_abort_i, dev_reset_i} = 5'h00;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_sys_i);
        #1 reset_n_i = 1'h1;
        repeat (4) @(posedge clk_sys_i);
        // first select lands off the sampling edge
        #1;
        t_stream();
        t_wel();
        t_lock();
        t_events();
        t_allow();
        t_busy();
        complete_run();
    end

    // about 93 us of serial traffic, twice that as margin
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule
